/* File: dv/aspp_chk_assertions.sv */
// Port checker for the two-port serial block.
// Assumes an APB master that leaves one idle cycle between transfers.
`timescale 1ns/100ps
module aspp_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [1:0] tx_pin,
    input wire [1:0] rx_pin,
    input wire [1:0] cts_n_pin,
    input wire [1:0] rts_n_pin,
    input wire irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire mapped = paddr[11:6] == 6'h00 && paddr[4:0] <= 5'h18 && paddr[1:0] == 2'h0;
    // ==========================================================
    // Bus answers
    property p_ready; psel |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_unmapped; acc && !mapped |-> pslverr && prdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
    property p_mapped; acc && mapped |-> !pslverr; endproperty
    a_mapped: assert property (p_mapped) else $error("mapped refused");
    property p_index; acc && !pwrite && mapped && paddr[4:0] == 5'h18 |-> prdata == {31'h0, paddr[5]}; endproperty
    a_index: assert property (p_index) else $error("wrong port index");
    property p_wr_zero; acc && pwrite |-> prdata == 32'h0; endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("read data on write");
    // ==========================================================
    // Control readback and lines
    sequence s_ctrl_wr; acc && pwrite && mapped && paddr[4:0] == 5'h08; endsequence
    sequence s_rd_setup; !psel ##1 (psel && !penable && !pwrite); endsequence
    property p_ctrl_rb;
        s_ctrl_wr ##1 s_rd_setup ##0 paddr == $past(paddr, 2) ##1 acc
            |-> prdata[9:0] == $past(pwdata[9:0], 3);
    endproperty
    a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback");
    property p_rst_idle; $rose(presetn) |-> tx_pin == 2'h3 && rts_n_pin == 2'h3 && !irq; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("lines not idle");
    property p_start; $fell(tx_pin[0]) |-> !tx_pin[0] [*8]; endproperty
    a_start: assert property (p_start) else $error("start bit short");
    sequence s_brk_wr; acc && pwrite && paddr == 12'h008 && pwdata[0] && pwdata[2]; endsequence
    property p_break; s_brk_wr |-> ##3 !tx_pin[0] [*4]; endproperty
    a_break: assert property (p_break) else $error("break not low");
endmodule
bind aspp_top aspp_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_pin(tx_pin), .rx_pin(rx_pin), .cts_n_pin(cts_n_pin), .rts_n_pin(rts_n_pin), .irq(irq)
);

/* File: dv/aspp_remote.sv */
// Remote serial device on both ports: captures, sends, gates sending.
// Assumes clk is the block's pclk and BIT pclk cycles per bit.
`timescale 1ns/100ps
module aspp_remote #(
    parameter BIT = 32
) (
    input wire clk,
    input wire [1:0] tx_pin,
    output logic [1:0] rx_pin,
    output logic [1:0] cts_n_pin
);
    int nb [2] = '{9, 9};
    int cnt [2] = '{0, 0};
    logic [11:0] last [2];
    initial begin
        rx_pin = 2'h3; // Idle high
        cts_n_pin = 2'h0;
    end
    // ==========================================================
    // Capture at bit centres, LSB first
    task automatic listen(input int p);
        logic [11:0] v = 12'h000;
        wait (tx_pin[p] === 1'b1);
        wait (tx_pin[p] === 1'b0);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < nb[p]; i++) begin
            repeat (BIT) @(posedge clk);
            v[i] = tx_pin[p];
        end
        last[p] = v;
        cnt[p]++;
    endtask
    always listen(0);
    always listen(1);
    // ==========================================================
    // Send: low start, n bits LSB first, back to idle
    task automatic send(input int p, input logic [11:0] v, input int n);
        rx_pin[p] <= 1'b0;
        repeat (BIT) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rx_pin[p] <= v[i];
            repeat (BIT) @(posedge clk);
        end
        rx_pin[p] <= 1'b1;
        repeat (BIT) @(posedge clk);
    endtask
    // Clear-to-send, high stops the block
    task automatic gate(input int p, input logic stop);
        cts_n_pin[p] <= stop;
    endtask
endmodule

/* File: dv/tb_top.sv */
// Self-checking bench for the two-port serial block.
// Assumes small FIFOs and the remote model on both ports.
`timescale 1ns/100ps
module tb_top;
    localparam DEPTH = 8;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready, pslverr, irq;
    wire [1:0] tx_pin, rx_pin, cts_n_pin, rts_n_pin;
    int fail_count = 0, cmp_count = 0;
    logic [31:0] rd;
    logic err;
    always #50 pclk = ~pclk;
    aspp_top #(.FIFO_DEPTH(DEPTH), .FIFO_AW(3)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_pin(tx_pin),
        .rx_pin(rx_pin), .cts_n_pin(cts_n_pin), .rts_n_pin(rts_n_pin), .irq(irq));
    aspp_remote #(.BIT(32)) REM (.clk(pclk), .tx_pin(tx_pin), .rx_pin(rx_pin),
        .cts_n_pin(cts_n_pin));
    // ==========================================================
    // Bus and compare tasks
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] m,
        input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd & m);
    endtask
    task automatic set_ctrl(input int p, input logic [31:0] v);
        apb(1'b1, 12'(p * 32 + 8), v);
        rdc("ctrl", 12'(p * 32 + 8), 32'h3ff, v);
    endtask
    task automatic wait_frame(input int p);
        int c = REM.cnt[p];
        while (REM.cnt[p] == c) @(posedge pclk);
    endtask
    function automatic logic [11:0] frm(input logic [7:0] d, input int nd, input int par,
        input int st, output int n);
        logic [11:0] v = 12'h000;
        for (n = 0; n < nd; n++) v[n] = d[n];
        if (par == 1 || par == 2) begin
            v[n] = (^v[7:0]) ^ (par == 2);
            n++;
        end
        v[n] = 1'b1;
        if (st == 2) v[n + 1] = 1'b1;
        n = n + st;
        return v;
    endfunction
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge pclk);
        fail_count++;
        give_verdict();
    end
    // ==========================================================
    // Test sequence
    initial begin
        int p;
        int n;
        logic [11:0] v;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (p = 0; p < 2; p++) begin
            rdc("ctrl reset", 12'(p * 32 + 8), 32'h3ff, 32'h182);
            rdc("div reset", 12'(p * 32 + 12), 32'hffff, 32'h40);
            rdc("index", 12'(p * 32 + 24), 32'hffffffff, p);
            rdc("stat", 12'(p * 32 + 4), 32'h1f, 32'h6);
            rdc("ista", 12'(p * 32 + 16), 32'h7, 32'h2);
            apb(1'b1, 12'(p * 32 + 12), 32'h1);
            rdc("div", 12'(p * 32 + 12), 32'hffff, 32'h1);
        end
        apb(1'b0, 12'h01c, 32'h0);
        chk("unmapped err", 1, err);
        chk("unmapped data", 0, rd);
        apb(1'b1, 12'h040, 32'h1);
        chk("high addr err", 1, err);
        $display("test registers done");
        apb(1'b1, 12'h000, 32'h3c);
        repeat (500) @(posedge pclk);
        chk("lines while off", 32'hf, {rts_n_pin, tx_pin});
        chk("frames while off", 0, REM.cnt[0]);
        set_ctrl(0, 32'h183);
        wait_frame(0);
        chk("frame after enable", 12'h13c, REM.last[0]);
        $display("test enable done");
        for (int i = 0; i < 4; i++) begin
            p = i % 2;
            v = frm(8'hc3 + 8'(i), 8 - i, i, 1 + i / 2, n);
            REM.nb[p] = n;
            set_ctrl(p, 32'h3 | (i << 5) | ((3 - i) << 7) | ((i / 2) << 9));
            apb(1'b1, 12'(p * 32), 32'hc3 + i);
            wait_frame(p);
            chk("format frame", v, REM.last[p]);
        end
        $display("test formats done");
        set_ctrl(1, 32'h183);
        apb(1'b1, 12'h030, 32'h7);
        apb(1'b1, 12'h034, 32'h0);
        REM.send(1, 12'h196, 9);
        repeat (40) @(posedge pclk);
        rdc("rx avail", 12'h024, 32'h1, 32'h1);
        chk("masked irq", 0, irq);
        apb(1'b1, 12'h034, 32'h1);
        @(posedge pclk);
        chk("irq raised", 1, irq);
        rdc("rx data", 12'h020, 32'h7ff, 32'h96);
        rdc("rx empty", 12'h024, 32'h1, 32'h0);
        apb(1'b1, 12'h030, 32'h1);
        @(posedge pclk);
        chk("irq cleared", 0, irq);
        $display("test receive done");
        REM.nb[0] = 9;
        REM.gate(0, 1'b1);
        set_ctrl(0, 32'h18b);
        for (int i = 0; i < DEPTH; i++) apb(1'b1, 12'h000, 32'h40 + i);
        rdc("tx full", 12'h004, 32'h2, 32'h0);
        repeat (300) @(posedge pclk);
        chk("held by cts", 1, tx_pin[0]);
        REM.gate(0, 1'b0);
        for (int i = 0; i < DEPTH; i++) wait_frame(0);
        chk("last of burst", 12'h147, REM.last[0]);
        repeat (40) @(posedge pclk);
        rdc("drained", 12'h004, 32'h6, 32'h6);
        REM.gate(0, 1'b1);
        set_ctrl(0, 32'h189);
        apb(1'b1, 12'h000, 32'h55);
        rdc("one deep full", 12'h004, 32'h2, 32'h0);
        REM.gate(0, 1'b0);
        wait_frame(0);
        chk("one deep frame", 12'h155, REM.last[0]);
        $display("test flow done");
        set_ctrl(0, 32'h187);
        repeat (100) @(posedge pclk);
        chk("break low", 0, tx_pin[0]);
        set_ctrl(0, 32'h183);
        repeat (20) @(posedge pclk);
        chk("break released", 1, tx_pin[0]);
        $display("test break done");
        give_verdict();
    end
endmodule

/* File: hw/aspp_defines.vh */
// Constants for the two-port asynchronous serial block.
// Assumes byte addresses on a 32-bit APB, one aligned word per register.
`ifndef ASPP_DEFINES_VH
`define ASPP_DEFINES_VH
// ==========================================================
// Register offsets within one port window
`define ASPP_OFF_DATA 5'h00
`define ASPP_OFF_STAT 5'h04
`define ASPP_OFF_CTRL 5'h08
`define ASPP_OFF_DIV 5'h0c
`define ASPP_OFF_ISTA 5'h10
`define ASPP_OFF_IMASK 5'h14
`define ASPP_OFF_INDEX 5'h18
// Address bit picking the port, upper bits that must be zero
`define ASPP_PORT_BIT 5
`define ASPP_ADDR_MSB 11
// ==========================================================
// Control fields
`define ASPP_CTRL_EN 0
`define ASPP_CTRL_FIFO 1
`define ASPP_CTRL_BRK 2
`define ASPP_CTRL_CTS 3
`define ASPP_CTRL_RTS 4
`define ASPP_CTRL_PAR_LO 5
`define ASPP_CTRL_PAR_HI 6
`define ASPP_CTRL_WLEN_LO 7
`define ASPP_CTRL_WLEN_HI 8
`define ASPP_CTRL_STOP2 9
`define ASPP_CTRL_W 10
`define ASPP_CTRL_RST 10'h182
`define ASPP_PAR_EVEN 2'h1
`define ASPP_PAR_ODD 2'h2
// ==========================================================
// Divider, oversampling, interrupt bits, RTS margin
`define ASPP_DIV_W 16
`define ASPP_DIV_RST 16'h0040
`define ASPP_OVS_LAST 4'hf
`define ASPP_OVS_MID 4'h7
`define ASPP_IRQ_RX 0
`define ASPP_IRQ_TX 1
`define ASPP_IRQ_ERR 2
`define ASPP_IRQ_W 3
`define ASPP_RTS_MARGIN 4
`endif

/* File: hw/aspp_fifo.v */
// Flip-flop FIFO with valid/ready on both sides and a one-entry mode.
// Assumes a single clock and asynchronous active-low reset.
`timescale 1ns/100ps
`include "aspp_defines.vh"
module aspp_fifo #(
    parameter W = 8,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk,
    input wire rst_n,
    input wire one_deep,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data,
    output wire [AW:0] level
);
    localparam [AW:0] FULL_CNT = DEPTH[AW:0];
    reg [W-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wp_q;
    reg [AW-1:0] rp_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;

    // ==========================================================
    // Flags
    assign in_ready = one_deep ? (cnt_q == {(AW+1){1'b0}}) : (cnt_q != FULL_CNT);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem_q[rp_q];
    assign level = cnt_q;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // ==========================================================
    // Pointers and storage
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            if (push & ~pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop & ~push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    always @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end
endmodule

/* File: hw/aspp_top.v */
// Two identical asynchronous serial ports behind one APB slave.
// Assumes serial pins are asynchronous to pclk; APB master on pclk.
// Functional notes
// - Two identical ports, index zero or one
// - Only transmit, receive, RTS, CTS lines
// - Parity none, even or odd, both directions
// - Programmable divider sets the bit rate
// - Break holds transmit line low
// - Status shows receive FIFO not empty
// - Status shows transmit FIFO has room
// - Status shows transmitter fully drained
// - Configure, then enable; enable reads back
// - Disabled port stays idle on lines
// - Five to eight data, one or two stops
// - FIFOs on by default, else one-deep
// - CTS gates sending, RTS follows occupancy
// - Maskable receive-data and transmit-need interrupts
`timescale 1ns/100ps
`include "aspp_defines.vh"
module aspp_top #(
    parameter FIFO_DEPTH = 32,
    parameter FIFO_AW = 5
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output wire [1:0] tx_pin,
    input wire [1:0] rx_pin,
    input wire [1:0] cts_n_pin,
    output wire [1:0] rts_n_pin,
    output wire irq
);
    localparam [4:0] ST_IDLE = 5'b00001;
    localparam [4:0] ST_START = 5'b00010;
    localparam [4:0] ST_DATA = 5'b00100;
    localparam [4:0] ST_PAR = 5'b01000;
    localparam [4:0] ST_STOP = 5'b10000;
    localparam integer RTS_LIM_I = FIFO_DEPTH - `ASPP_RTS_MARGIN;
    localparam [FIFO_AW:0] RTS_LIM = RTS_LIM_I[FIFO_AW:0];

    // ==========================================================
    // APB decode
    wire [4:0] off = paddr[4:0];
    wire hi_zero = (paddr[`ASPP_ADDR_MSB:`ASPP_PORT_BIT+1] == 6'h00);
    wire off_hit = (off[1:0] == 2'h0) & (off <= `ASPP_OFF_INDEX);
    wire hit = hi_zero & off_hit;
    wire acc = psel & penable;
    wire wr_en = acc & pwrite & hit;
    wire rd_en = acc & ~pwrite & hit;
    wire [31:0] rdat [0:1];
    wire [1:0] irq_p;

    assign pready = 1'b1;
    assign pslverr = acc & ~hit;
    assign irq = |irq_p;

    // Read data is captured in the setup cycle, shown in the access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel & ~penable) begin
            prdata <= (hit & ~pwrite) ? rdat[paddr[`ASPP_PORT_BIT]] : 32'h0;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_port
            wire sel = (paddr[`ASPP_PORT_BIT] == gi);
            wire wr = wr_en & sel;
            reg [`ASPP_CTRL_W-1:0] ctrl_q;
            reg [`ASPP_DIV_W-1:0] div_q;
            reg [`ASPP_IRQ_W-1:0] ista_q;
            reg [`ASPP_IRQ_W-1:0] imask_q;
            reg [`ASPP_DIV_W-1:0] bcnt_q;
            reg [4:0] tst_q;
            reg [7:0] tsh_q;
            reg [2:0] tbit_q;
            reg [3:0] tph_q;
            reg tpar_q;
            reg tx_q;
            reg [4:0] rst_q;
            reg [7:0] rsh_q;
            reg [2:0] rbit_q;
            reg [3:0] rph_q;
            reg rpar_q;
            reg rperr_q;
            reg rx1_q;
            reg rx2_q;
            reg cts1_q;
            reg cts2_q;
            reg rts_n_q;
            reg tfe_q;
            wire en = ctrl_q[`ASPP_CTRL_EN];
            wire [1:0] par = ctrl_q[`ASPP_CTRL_PAR_HI:`ASPP_CTRL_PAR_LO];
            wire par_on = (par == `ASPP_PAR_EVEN) | (par == `ASPP_PAR_ODD);
            wire par_odd = (par == `ASPP_PAR_ODD);
            wire [2:0] last_bit = {1'b0, ctrl_q[`ASPP_CTRL_WLEN_HI:`ASPP_CTRL_WLEN_LO]} + 3'h4;
            wire tick = (bcnt_q == {`ASPP_DIV_W{1'b0}});
            wire t_end = tick & (tph_q == `ASPP_OVS_LAST);
            wire r_end = tick & (rph_q == `ASPP_OVS_LAST);
            wire tf_in_rdy;
            wire tf_valid;
            wire [7:0] tf_data;
            wire [FIFO_AW:0] tf_level;
            wire rf_in_rdy;
            wire rf_valid;
            wire [10:0] rf_data;
            wire [FIFO_AW:0] rf_level;
            wire cts_ok = ~ctrl_q[`ASPP_CTRL_CTS] | ~cts2_q;
            wire tx_load = en & tst_q[0] & tf_valid & cts_ok;
            wire tx_idle = ~tf_valid & tst_q[0];
            wire rx_done = rst_q[4] & r_end;
            wire [7:0] rdata = rsh_q >> (3'h7 - last_bit);
            wire rbrk = ~rx2_q & (rdata == 8'h00);
            wire rx_push = rx_done & rf_in_rdy;
            wire rx_err = rx_done & (~rx2_q | rperr_q | ~rf_in_rdy);
            wire rd_pop = rd_en & sel & (off == `ASPP_OFF_DATA);
            wire [`ASPP_IRQ_W-1:0] ev;
            reg [31:0] rd_c;

            aspp_fifo #(.W(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_txf (
                .clk(pclk),
                .rst_n(presetn),
                .one_deep(~ctrl_q[`ASPP_CTRL_FIFO]),
                .in_valid(wr & (off == `ASPP_OFF_DATA)),
                .in_ready(tf_in_rdy),
                .in_data(pwdata[7:0]),
                .out_valid(tf_valid),
                .out_ready(tx_load),
                .out_data(tf_data),
                .level(tf_level)
            );

            aspp_fifo #(.W(11), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rxf (
                .clk(pclk),
                .rst_n(presetn),
                .one_deep(~ctrl_q[`ASPP_CTRL_FIFO]),
                .in_valid(rx_done),
                .in_ready(rf_in_rdy),
                .in_data({rbrk, ~rx2_q, rperr_q, rdata}),
                .out_valid(rf_valid),
                .out_ready(rd_pop),
                .out_data(rf_data),
                .level(rf_level)
            );

            // ==========================================================
            // Registers and sticky interrupt status
            assign ev = {rx_err, tf_valid == 1'b0 && tfe_q == 1'b0, rx_push};
            assign irq_p[gi] = |(ista_q & imask_q);
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ctrl_q <= `ASPP_CTRL_RST;
                    div_q <= `ASPP_DIV_RST;
                    ista_q <= {`ASPP_IRQ_W{1'b0}};
                    imask_q <= {`ASPP_IRQ_W{1'b0}};
                    tfe_q <= 1'b0;
                end else begin
                    tfe_q <= ~tf_valid;
                    if (wr & (off == `ASPP_OFF_CTRL)) begin
                        ctrl_q <= pwdata[`ASPP_CTRL_W-1:0];
                    end
                    if (wr & (off == `ASPP_OFF_DIV)) begin
                        div_q <= pwdata[`ASPP_DIV_W-1:0];
                    end
                    if (wr & (off == `ASPP_OFF_IMASK)) begin
                        imask_q <= pwdata[`ASPP_IRQ_W-1:0];
                    end
                    if (wr & (off == `ASPP_OFF_ISTA)) begin
                        ista_q <= (ista_q & ~pwdata[`ASPP_IRQ_W-1:0]) | ev;
                    end else begin
                        ista_q <= ista_q | ev;
                    end
                end
            end

            always @* begin
                rd_c = 32'h0;
                case (off)
                    `ASPP_OFF_DATA: rd_c = rf_valid ? {21'h0, rf_data} : 32'h0;
                    `ASPP_OFF_STAT: rd_c = {27'h0, en, ~tst_q[0], tx_idle,
                        tf_in_rdy, rf_valid};
                    `ASPP_OFF_CTRL: rd_c = {22'h0, ctrl_q};
                    `ASPP_OFF_DIV: rd_c = {16'h0, div_q};
                    `ASPP_OFF_ISTA: rd_c = {29'h0, ista_q};
                    `ASPP_OFF_IMASK: rd_c = {29'h0, imask_q};
                    `ASPP_OFF_INDEX: rd_c = gi;
                    default: rd_c = 32'h0;
                endcase
            end
            assign rdat[gi] = rd_c;

            // ==========================================================
            // Baud tick at 16x the bit rate, pin synchronisers, RTS
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    bcnt_q <= {`ASPP_DIV_W{1'b0}};
                    rx1_q <= 1'b1;
                    rx2_q <= 1'b1;
                    cts1_q <= 1'b1;
                    cts2_q <= 1'b1;
                    rts_n_q <= 1'b1;
                end else begin
                    bcnt_q <= (tick | ~en) ? div_q : bcnt_q - 1'b1;
                    rx1_q <= rx_pin[gi];
                    rx2_q <= rx1_q;
                    cts1_q <= cts_n_pin[gi];
                    cts2_q <= cts1_q;
                    rts_n_q <= ~(en & (~ctrl_q[`ASPP_CTRL_RTS] |
                        (ctrl_q[`ASPP_CTRL_FIFO] ? (rf_level < RTS_LIM) : rf_in_rdy)));
                end
            end
            assign rts_n_pin[gi] = rts_n_q;
            assign tx_pin[gi] = tx_q;

            // ==========================================================
            // Transmitter
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    tst_q <= ST_IDLE;
                    tsh_q <= 8'h00;
                    tbit_q <= 3'h0;
                    tph_q <= 4'h0;
                    tpar_q <= 1'b0;
                    tx_q <= 1'b1;
                end else begin
                    if (!en) begin
                        tx_q <= 1'b1;
                    end else if (ctrl_q[`ASPP_CTRL_BRK]) begin
                        tx_q <= 1'b0;
                    end else begin
                        case (tst_q)
                            ST_START: tx_q <= 1'b0;
                            ST_DATA: tx_q <= tsh_q[0];
                            ST_PAR: tx_q <= tpar_q ^ par_odd;
                            default: tx_q <= 1'b1;
                        endcase
                    end
                    if (tick) begin
                        tph_q <= tph_q + 1'b1;
                    end
                    if (!en) begin
                        tst_q <= ST_IDLE;
                    end else begin
                        case (tst_q)
                            ST_IDLE: begin
                                if (tx_load) begin
                                    tsh_q <= tf_data;
                                    tpar_q <= 1'b0;
                                    tph_q <= 4'h0;
                                    tbit_q <= 3'h0;
                                    tst_q <= ST_START;
                                end
                            end
                            ST_START: begin
                                if (t_end) begin
                                    tst_q <= ST_DATA;
                                end
                            end
                            ST_DATA: begin
                                if (t_end) begin
                                    tpar_q <= tpar_q ^ tsh_q[0];
                                    tsh_q <= {1'b0, tsh_q[7:1]};
                                    tbit_q <= tbit_q + 1'b1;
                                    if (tbit_q == last_bit) begin
                                        tbit_q <= 3'h0;
                                        tst_q <= par_on ? ST_PAR : ST_STOP;
                                    end
                                end
                            end
                            ST_PAR: begin
                                if (t_end) begin
                                    tst_q <= ST_STOP;
                                end
                            end
                            ST_STOP: begin
                                if (t_end) begin
                                    tbit_q <= tbit_q + 1'b1;
                                    if (tbit_q[0] == ctrl_q[`ASPP_CTRL_STOP2]) begin
                                        tst_q <= ST_IDLE;
                                    end
                                end
                            end
                            default: tst_q <= ST_IDLE;
                        endcase
                    end
                end
            end

            // ==========================================================
            // Receiver
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rst_q <= ST_IDLE;
                    rsh_q <= 8'h00;
                    rbit_q <= 3'h0;
                    rph_q <= 4'h0;
                    rpar_q <= 1'b0;
                    rperr_q <= 1'b0;
                end else if (!en) begin
                    rst_q <= ST_IDLE;
                end else begin
                    if (tick) begin
                        rph_q <= rph_q + 1'b1;
                    end
                    case (rst_q)
                        ST_IDLE: begin
                            rph_q <= 4'h0;
                            if (!rx2_q) begin
                                rst_q <= ST_START;
                            end
                        end
                        ST_START: begin
                            if (tick && rph_q == `ASPP_OVS_MID) begin
                                rph_q <= 4'h0;
                                rbit_q <= 3'h0;
                                rpar_q <= 1'b0;
                                rperr_q <= 1'b0;
                                rst_q <= rx2_q ? ST_IDLE : ST_DATA;
                            end
                        end
                        ST_DATA: begin
                            if (r_end) begin
                                rsh_q <= {rx2_q, rsh_q[7:1]};
                                rpar_q <= rpar_q ^ rx2_q;
                                rbit_q <= rbit_q + 1'b1;
                                if (rbit_q == last_bit) begin
                                    rst_q <= par_on ? ST_PAR : ST_STOP;
                                end
                            end
                        end
                        ST_PAR: begin
                            if (r_end) begin
                                rperr_q <= rx2_q ^ rpar_q ^ par_odd;
                                rst_q <= ST_STOP;
                            end
                        end
                        ST_STOP: begin
                            if (r_end) begin
                                rst_q <= ST_IDLE;
                            end
                        end
                        default: rst_q <= ST_IDLE;
                    endcase
                end
            end
        end
    endgenerate
endmodule
